/* File: inc/ingress_policy_pkg.sv */
package ingress_policy_pkg;
  localparam int         NUM_PORTS       = 5;
  localparam int         PORT_W          = 3;
  localparam int         PRIO_W          = 3;
  localparam int         VID_W           = 12;
  localparam int         DATA_W          = 32;
  localparam int         ADDR_W          = 12;
  localparam int         CTRL_W          = 8;
  // Register indices; byte address is four times the index
  localparam logic [9:0] CTRL_IDX [NUM_PORTS] = '{10'h012, 10'h022, 10'h032, 10'h042, 10'h052};
  localparam int         CEIL_BIT        = 7;
  localparam int         VLAN_CHK_BIT    = 6;
  localparam int         FOREIGN_VID_BIT = 5;
  localparam int         FORCE_FC_BIT    = 4;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [1:0] HRESP_OKAY      = 2'h0;
endpackage : ingress_policy_pkg

/* File: core/policy_eval.sv */
`timescale 1ns/1ps
module policy_eval
  import ingress_policy_pkg::*;
(
  input  wire logic [ingress_policy_pkg::CTRL_W-1:0] ctrl_i,
  input  wire logic                                  port_ok_i,
  input  wire logic                                  member_i,
  input  wire logic [ingress_policy_pkg::PRIO_W-1:0] prio_i,
  input  wire logic [ingress_policy_pkg::VID_W-1:0]  vid_i,
  input  wire logic [ingress_policy_pkg::PRIO_W-1:0] def_prio_i,
  input  wire logic [ingress_policy_pkg::VID_W-1:0]  def_vid_i,
  output logic      [ingress_policy_pkg::PRIO_W-1:0] prio_o,
  output logic                                       drop_o
);
  import ingress_policy_pkg::*;

  logic member_fail;
  logic vid_fail;

  always_comb begin
    prio_o = prio_i;
    if (port_ok_i && ctrl_i[CEIL_BIT] && (prio_i > def_prio_i)) begin // [R1] [R2]
      prio_o = def_prio_i;
    end
    member_fail = port_ok_i && ctrl_i[VLAN_CHK_BIT] && !member_i;           // [R3]
    vid_fail    = port_ok_i && ctrl_i[FOREIGN_VID_BIT] && (vid_i != def_vid_i); // [R4]
    drop_o      = member_fail || vid_fail;                                   // [R7]
  end
endmodule : policy_eval

/* File: core/ingress_policy_ctrl.sv */
// Contract
// R1: Ceiling set: priority above port default tag priority is replaced by it.
// R2: Ceiling clear: frame priority passes unchanged, no comparison.
// R3: VLAN check set: drop frames whose VID membership excludes ingress port.
// R4: Foreign-VID drop set: drop frames whose VID differs from port default VID.
// R5: Force flow control set: rx and tx pause enabled regardless of negotiation.
// R6: Force flow control clear: pause enables follow the negotiation result.
// R7: Failing either enabled check drops; settings apply to their own port only.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module ingress_policy_ctrl
  import ingress_policy_pkg::*;
(
  input  wire logic                                    CLK_I,
  input  wire logic                                    RST_B_I,
  input  wire logic                                    CE_I,
  input  wire logic                                    HSEL_I,
  input  wire logic [ingress_policy_pkg::ADDR_W-1:0]   HADDR_I,
  input  wire logic [1:0]                              HTRANS_I,
  input  wire logic                                    HWRITE_I,
  input  wire logic [2:0]                              HSIZE_I,
  input  wire logic                                    HREADY_I,
  input  wire logic [ingress_policy_pkg::DATA_W-1:0]   HWDATA_I,
  output logic      [ingress_policy_pkg::DATA_W-1:0]   HRDATA_O,
  output logic                                         HREADYOUT_O,
  output logic      [1:0]                              HRESP_O,
  input  wire logic                                    FRM_VALID_I,
  input  wire logic [ingress_policy_pkg::PORT_W-1:0]   FRM_PORT_I,
  input  wire logic [ingress_policy_pkg::PRIO_W-1:0]   FRM_PRIO_I,
  input  wire logic [ingress_policy_pkg::VID_W-1:0]    FRM_VID_I,
  input  wire logic [ingress_policy_pkg::NUM_PORTS-1:0] FRM_MEMBER_I,
  input  wire logic [ingress_policy_pkg::PRIO_W-1:0]   DEF_PRIO_I,
  input  wire logic [ingress_policy_pkg::VID_W-1:0]    DEF_VID_I,
  input  wire logic [ingress_policy_pkg::NUM_PORTS-1:0] AN_RX_PAUSE_I,
  input  wire logic [ingress_policy_pkg::NUM_PORTS-1:0] AN_TX_PAUSE_I,
  output logic                                         RES_VALID_O,
  output logic      [ingress_policy_pkg::PRIO_W-1:0]   RES_PRIO_O,
  output logic                                         RES_DROP_O,
  output logic      [ingress_policy_pkg::NUM_PORTS-1:0] RX_PAUSE_EN_O,
  output logic      [ingress_policy_pkg::NUM_PORTS-1:0] TX_PAUSE_EN_O
);
  import ingress_policy_pkg::*;

  function automatic logic [PORT_W:0] decode(input logic [ADDR_W-1:0] addr);
    logic [PORT_W:0] res;
    res = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (addr[ADDR_W-1:2] == CTRL_IDX[p]) begin
        res = {1'b1, PORT_W'(p)};
      end
    end
    return res;
  endfunction : decode

  logic [CTRL_W-1:0]    ctrl [NUM_PORTS];
  logic [CTRL_W-1:0]    next_ctrl [NUM_PORTS];
  logic                 wr_pend;
  logic                 next_wr_pend;
  logic [PORT_W-1:0]    wr_port;
  logic [PORT_W-1:0]    next_wr_port;
  logic [DATA_W-1:0]    next_rdata;
  logic                 acc;
  logic [PORT_W:0]      hit;

  assign acc = HSEL_I && HREADY_I && HTRANS_I[1];
  assign hit = decode(HADDR_I);

  // Zero wait states; a read right behind a write to the same register sees the new byte
  always_comb begin
    next_ctrl    = ctrl;
    next_wr_pend = acc && HWRITE_I && hit[PORT_W];
    next_wr_port = hit[PORT_W-1:0];
    next_rdata   = HRDATA_O;
    if (wr_pend) begin
      next_ctrl[wr_port] = HWDATA_I[CTRL_W-1:0];
    end
    if (acc && !HWRITE_I) begin
      next_rdata = '0;
      if (hit[PORT_W]) begin
        if (wr_pend && (wr_port == hit[PORT_W-1:0])) begin
          next_rdata[CTRL_W-1:0] = HWDATA_I[CTRL_W-1:0];
        end else begin
          next_rdata[CTRL_W-1:0] = ctrl[hit[PORT_W-1:0]];
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        ctrl[p] <= CTRL_RESET;
      end
      wr_pend     <= 1'b0;
      wr_port     <= '0;
      HRDATA_O    <= '0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= HRESP_OKAY;
    end else if (CE_I) begin
      ctrl        <= next_ctrl;
      wr_pend     <= next_wr_pend;
      wr_port     <= next_wr_port;
      HRDATA_O    <= next_rdata;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= HRESP_OKAY;
    end
  end

  // Only the ingress port's own control byte is consulted for the frame result
  logic                 port_ok;
  logic [CTRL_W-1:0]    frm_ctrl;
  logic                 frm_member;
  logic [PRIO_W-1:0]    eval_prio;
  logic                 eval_drop;
  logic [NUM_PORTS-1:0] force_vec;
  logic                 next_res_valid;
  logic [PRIO_W-1:0]    next_res_prio;
  logic                 next_res_drop;
  logic [NUM_PORTS-1:0] next_rx_pause;
  logic [NUM_PORTS-1:0] next_tx_pause;

  always_comb begin
    port_ok    = (FRM_PORT_I < PORT_W'(NUM_PORTS));
    frm_ctrl   = port_ok ? ctrl[FRM_PORT_I] : CTRL_RESET;                   // [R7]
    frm_member = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      force_vec[p] = ctrl[p][FORCE_FC_BIT];
      if (FRM_PORT_I == PORT_W'(p)) begin
        frm_member = FRM_MEMBER_I[p];
      end
    end
  end

  policy_eval policy_eval_inst (
    .ctrl_i     (frm_ctrl),
    .port_ok_i  (port_ok),
    .member_i   (frm_member),
    .prio_i     (FRM_PRIO_I),
    .vid_i      (FRM_VID_I),
    .def_prio_i (DEF_PRIO_I),
    .def_vid_i  (DEF_VID_I),
    .prio_o     (eval_prio),
    .drop_o     (eval_drop)
  );

  always_comb begin
    next_res_valid = FRM_VALID_I;
    next_res_prio  = FRM_VALID_I ? eval_prio : RES_PRIO_O;
    next_res_drop  = FRM_VALID_I ? eval_drop : RES_DROP_O;
    next_rx_pause  = force_vec | AN_RX_PAUSE_I;                             // [R5] [R6]
    next_tx_pause  = force_vec | AN_TX_PAUSE_I;                             // [R5] [R6]
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RES_VALID_O   <= 1'b0;
      RES_PRIO_O    <= '0;
      RES_DROP_O    <= 1'b0;
      RX_PAUSE_EN_O <= '0;
      TX_PAUSE_EN_O <= '0;
    end else if (CE_I) begin
      RES_VALID_O   <= next_res_valid;
      RES_PRIO_O    <= next_res_prio;
      RES_DROP_O    <= next_res_drop;
      RX_PAUSE_EN_O <= next_rx_pause;
      TX_PAUSE_EN_O <= next_tx_pause;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  // Reset in the antecedent: flops still hold reset at the release edge
  sequence seq_frame;
    CE_I && RST_B_I && FRM_VALID_I && port_ok;
  endsequence

  AST_CEIL_CLAMP: assert property ( // [R1]
    seq_frame ##0 frm_ctrl[CEIL_BIT] && (FRM_PRIO_I > DEF_PRIO_I)
      |=> RES_VALID_O && (RES_PRIO_O == $past(DEF_PRIO_I)))
    else $error("priority not clamped to default");

  AST_CEIL_OFF: assert property ( // [R2]
    seq_frame ##0 !frm_ctrl[CEIL_BIT] |=> RES_PRIO_O == $past(FRM_PRIO_I))
    else $error("priority altered with ceiling off");

  AST_MEMBER_DROP: assert property ( // [R3]
    seq_frame ##0 frm_ctrl[VLAN_CHK_BIT] && !FRM_MEMBER_I[FRM_PORT_I] |=> RES_DROP_O)
    else $error("non-member frame not dropped");

  AST_VID_DROP: assert property ( // [R4]
    seq_frame ##0 frm_ctrl[FOREIGN_VID_BIT] && (FRM_VID_I != DEF_VID_I) |=> RES_DROP_O)
    else $error("foreign vid frame not dropped");

  AST_FORCE_FC: assert property ( // [R5]
    CE_I && RST_B_I |=> ((($past(force_vec) & ~RX_PAUSE_EN_O) | ($past(force_vec) & ~TX_PAUSE_EN_O)) == '0))
    else $error("forced flow control not enabled");

  AST_AN_FC: assert property ( // [R6]
    CE_I && RST_B_I |=> ((~$past(force_vec) & (RX_PAUSE_EN_O ^ $past(AN_RX_PAUSE_I))) == '0)
      && ((~$past(force_vec) & (TX_PAUSE_EN_O ^ $past(AN_TX_PAUSE_I))) == '0))
    else $error("pause enable differs from negotiation");

  AST_DROP_EXACT: assert property ( // [R7]
    seq_frame |=> RES_DROP_O == $past((frm_ctrl[VLAN_CHK_BIT] && !frm_member)
      || (frm_ctrl[FOREIGN_VID_BIT] && (FRM_VID_I != DEF_VID_I))))
    else $error("drop decision wrong");

  sequence seq_stray_frame;
    CE_I && RST_B_I && FRM_VALID_I && !port_ok;
  endsequence

  AST_CEIL_KEEP: assert property ( // [R1]
    seq_frame ##0 frm_ctrl[CEIL_BIT] && (FRM_PRIO_I <= DEF_PRIO_I) |=> RES_PRIO_O == $past(FRM_PRIO_I))
    else $error("priority changed although within ceiling");

  AST_NO_CHECK_NO_DROP: assert property ( // [R3] [R4]
    seq_frame ##0 !frm_ctrl[VLAN_CHK_BIT] && !frm_ctrl[FOREIGN_VID_BIT] |=> !RES_DROP_O)
    else $error("frame dropped with both checks off");

  AST_OWN_MEMBER_KEEP: assert property ( // [R3] [R7]
    seq_frame ##0 frm_ctrl[VLAN_CHK_BIT] && FRM_MEMBER_I[FRM_PORT_I]
      && (!frm_ctrl[FOREIGN_VID_BIT] || (FRM_VID_I == DEF_VID_I)) |=> !RES_DROP_O)
    else $error("member frame dropped");

  // A frame tagged with no real port borrows no port's settings
  AST_STRAY_PORT: assert property ( // [R7]
    seq_stray_frame |=> RES_VALID_O && !RES_DROP_O && (RES_PRIO_O == $past(FRM_PRIO_I)))
    else $error("frame on unknown port altered");
endmodule : ingress_policy_ctrl

/* File: sim/ingress_policy_ctrl_tb_top.sv */
`timescale 1ns/1ps
module ingress_policy_ctrl_tb_top;
  import ingress_policy_pkg::*;
  logic        clk, rst_b, ce, hw, fv, hro, rv, rdrop;
  logic [1:0]  ht, hresp;
  logic [11:0] ha, fvid, dvid;
  logic [31:0] hwd, hrd, rd;
  logic [2:0]  fp, fpr, dp, rp;
  logic [4:0]  mem, anr, ant, rxe, txe;
  int          fails, num_checks;

  // HREADY looped back from the only slave on the bus
  ingress_policy_ctrl ingress_policy_ctrl_inst (.CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .HSEL_I(1'b1),
    .HADDR_I(ha), .HTRANS_I(ht), .HWRITE_I(hw), .HSIZE_I(3'h2), .HREADY_I(hro), .HWDATA_I(hwd),
    .HRDATA_O(hrd), .HREADYOUT_O(hro), .HRESP_O(hresp), .FRM_VALID_I(fv), .FRM_PORT_I(fp), .FRM_PRIO_I(fpr),
    .FRM_VID_I(fvid), .FRM_MEMBER_I(mem), .DEF_PRIO_I(dp), .DEF_VID_I(dvid), .AN_RX_PAUSE_I(anr),
    .AN_TX_PAUSE_I(ant), .RES_VALID_O(rv), .RES_PRIO_O(rp), .RES_DROP_O(rdrop), .RX_PAUSE_EN_O(rxe),
    .TX_PAUSE_EN_O(txe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  function automatic logic [11:0] addr(input int i);
    return {CTRL_IDX[i], 2'b00};
  endfunction : addr

  // Called just after an edge; waits on hready rather than assuming zero waits
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    ha <= a;
    ht <= 2'h2;
    hw <= w;
    do @(posedge clk); while (hro !== 1'b1);
    ht <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (hro !== 1'b1);
    rd = hrd;
    chk(hresp, HRESP_OKAY);
  endtask : bus

  task frame(input int p, input logic [2:0] pr, input logic [11:0] v, input logic [4:0] m,
             input logic [2:0] d_p, input logic [11:0] d_v, input logic [2:0] ep, input logic ed);
    fp <= p[2:0];
    fpr <= pr;
    fvid <= v;
    mem <= m;
    dp <= d_p;
    dvid <= d_v;
    fv <= 1'b1;
    @(posedge clk);
    fv <= 1'b0;
    #1;
    chk(rv, 1'b1);
    chk(rp, ep);
    chk(rdrop, ed);
    @(posedge clk);
  endtask : frame

  initial begin
    #100us;
    fails++;
    give_verdict;
  end

  initial begin
    {rst_b, hw, fv, ht, ha, hwd, fp, fpr, dp, fvid, dvid, mem, anr, ant} = '0;
    ce = 1'b1;
    repeat (11) @(posedge clk);
    #1;
    chk(hro, 1'b1);
    chk(hresp, HRESP_OKAY);
    chk(hrd, 32'h0);
    chk(rv, 1'b0);
    chk({rxe, txe}, 10'h000);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < NUM_PORTS; i++) begin
      bus(1'b0, addr(i), 32'h0);
      chk(rd, {24'h0, CTRL_RESET});
      bus(1'b1, addr(i), {24'hFFFFFF, 4'h0, i[3:0]});
      bus(1'b0, addr(i), 32'h0);
      chk(rd, {28'h0, i[3:0]});
    end
    bus(1'b1, 12'h04C, 32'hFFFFFFFF);
    bus(1'b0, 12'h04C, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
    bus(1'b1, addr(0), 32'h000000E0);
    bus(1'b1, addr(1), 32'h00000010);
    frame(0, 3'h5, 12'h123, 5'h01, 3'h3, 12'h123, 3'h3, 1'b0);
    frame(0, 3'h3, 12'h123, 5'h01, 3'h3, 12'h123, 3'h3, 1'b0);
    frame(0, 3'h2, 12'h123, 5'h01, 3'h3, 12'h123, 3'h2, 1'b0);
    frame(0, 3'h2, 12'h123, 5'h1E, 3'h3, 12'h123, 3'h2, 1'b1);
    frame(0, 3'h2, 12'h124, 5'h01, 3'h3, 12'h123, 3'h2, 1'b1);
    frame(1, 3'h7, 12'h124, 5'h00, 3'h0, 12'h123, 3'h7, 1'b0);
    frame(5, 3'h7, 12'h124, 5'h00, 3'h0, 12'h123, 3'h7, 1'b0);
    $display("frame test done");
    repeat (2) @(posedge clk);
    #1;
    chk(rxe, 5'h02);
    chk(txe, 5'h02);
    @(posedge clk);
    anr <= 5'h10;
    ant <= 5'h01;
    repeat (2) @(posedge clk);
    #1;
    chk(rxe, 5'h12);
    chk(txe, 5'h03);
    @(posedge clk);
    bus(1'b1, addr(1), 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk(rxe, 5'h10);
    chk(txe, 5'h01);
    $display("pause test done");
    // Enable low must freeze results and pause enables alike
    @(posedge clk);
    ce <= 1'b0;
    anr <= 5'h00;
    fv <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(rv, 1'b0);
    chk(rxe, 5'h10);
    @(posedge clk);
    ce <= 1'b1;
    fv <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(rxe, 5'h00);
    $display("enable test done");
    @(posedge clk);
    bus(1'b0, addr(0), 32'h0);
    chk(rd, 32'h000000E0);
    rst_b <= 1'b0;
    anr <= 5'h1F;
    repeat (2) @(posedge clk);
    #1;
    chk(hrd, 32'h0);
    chk(rp, 3'h0);
    chk(rxe, 5'h00);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, addr(0), 32'h0);
    chk(rd, {24'h0, CTRL_RESET});
    chk(rxe, 5'h1F);
    $display("reset test done");
    give_verdict;
  end
endmodule : ingress_policy_ctrl_tb_top
